/* File: hdl/cip_pkg.sv */
// Purpose: shared constants and types of the input cell poller
// Assumes: used by package scope only, never imported
// Notes: cell lengths and the polled PHY count are defaults for parameters; pin patterns are fixed
package cip_pkg;
  // ****************************************************
  // Cell geometry and polling limits
  // ****************************************************
  localparam int unsigned CELL_WORDS_NARROW = 53; // Octets per cell
  localparam int unsigned CELL_WORDS_WIDE = 27; // 16-bit words per cell
  localparam int unsigned NUM_PHY_POLL = 32;
  localparam int unsigned NUM_PHY_DIRECT = 4;
  localparam int unsigned LINK_MAX_MHZ = 52; // Far side keeps link clock under this
  // ****************************************************
  // Pin patterns and reset values
  // ****************************************************
  localparam logic [4:0] GAP_ADDR = 5'h1F;
  localparam logic [4:0] OE_POLL = 5'h1F; // All five address pins driven
  localparam logic [4:0] OE_DIRECT = 5'h07; // Only pull enables 4..2 driven
  localparam logic [3:0] WE_IDLE = 4'hF;
  localparam logic [3:0] WE_ONE = 4'hE; // Enable line one only
  localparam logic [4:0] STRAP_RESET = 5'h00;
  // ****************************************************
  // Strap vector field positions
  // ****************************************************
  localparam int unsigned STRAP_POLL = 0;
  localparam int unsigned STRAP_NARROW = 1;
  localparam int unsigned STRAP_ODD = 2;
  localparam int unsigned STRAP_WHOLE = 3;
  localparam int unsigned STRAP_CA_LOW = 4;
  // ****************************************************
  // Transfer state machine
  // ****************************************************
  typedef enum logic [2:0] {
    ST_HUNT = 3'h1,
    ST_GAP = 3'h2,
    ST_XFER = 3'h4
  } cip_state_t;
endpackage : cip_pkg

/* File: hdl/cip_poll.sv */
// Purpose: input cell interface master pulling cells from PHY devices
// Assumes: PHY pins are synchronous to in_iface_clk
// Notes: events cross to ref_clk as one-cycle pulses
// Function
// R1: Far side keeps the link clock at 52 MHz or below.
// R2: Inputs sampled and outputs updated on rising link clock edge.
// R3: Strap low: four enables pair with four cell-available lines.
// R4: Strap high: sequential address polling chooses next cell source.
// R5: Narrow strap selects 8-bit bus and one parity bit, else 16.
// R6: PHY presents data at second rising edge after enable falls.
// R7: Data, parity and first-word flag ignored while enables high.
// R8: Polling mode: enable pins 2..4 become address bits, line one transfers.
// R9: Direct mode: upper address pins are avail inputs, lower are enables.
// R10: Polling mode drives five address lines covering up to 32 PHYs.
// R11: Gap cycles drive address 1F and address-valid low.
// R12: No PHY drives avail line one in cycle after a gap.
// R13: Polled addresses step in incrementing sequential order.
// R14: PHY addressed when enable one falls is the transferring PHY.
// R15: Direct mode: address-valid pin is avail input four.
// R16: Address-valid high only with a valid PHY address.
// R17: Address-valid low forces address outputs to 1F.
// R18: Whole cell transferred once committed; avail sampled again afterwards.
// R19: First-word flag on a later word raises an event.
// R20: Odd or even parity per byte or word; mismatch raises event.
// R21: New cell started only when FIFO has room for a cell.
`timescale 1ns/1ps
`default_nettype none
module cip_poll #(
  parameter int unsigned NUM_PHY = cip_pkg::NUM_PHY_POLL,
  parameter int unsigned CELL_WORDS_NARROW = cip_pkg::CELL_WORDS_NARROW,
  parameter int unsigned CELL_WORDS_WIDE = cip_pkg::CELL_WORDS_WIDE
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic in_iface_clk,
  input wire logic poll_method_sel,
  input wire logic narrow_bus_sel,
  input wire logic par_odd_sel,
  input wire logic par_whole_sel,
  input wire logic ca_active_low,
  input wire logic cell_room,
  input wire logic phy_cell_avail_1,
  input wire logic [15:0] in_cell_word,
  input wire logic [1:0] in_word_parity,
  input wire logic in_first_word_flag,
  input wire logic [4:0] phy_sel_addr_i,
  input wire logic phy_sel_addr_valid_i,
  output logic cell_pull_en_n_1,
  output logic [4:0] phy_sel_addr_o,
  output logic [4:0] phy_sel_addr_oe,
  output logic phy_sel_addr_valid_o,
  output logic phy_sel_addr_valid_oe,
  output logic [15:0] rx_word,
  output logic rx_first,
  output logic rx_valid,
  output logic [4:0] rx_src,
  output logic par_err_evt,
  output logic soc_err_evt
);
  // ****************************************************
  // Link reset and crossings into the link domain
  // ****************************************************
  logic [1:0] lrst_q;
  logic lrst_n;
  logic [4:0] strap_m_q;
  logic [4:0] strap_q;
  logic room_ref_q;
  logic room_m_q;
  logic room_q;

  // Reset asserts at once, releases on link clock
  always_ff @(posedge in_iface_clk or negedge arst_n) begin
    if (!arst_n) begin
      lrst_q <= 2'h0;
    end else begin
      lrst_q <= {lrst_q[0], 1'h1};
    end
  end
  assign lrst_n = lrst_q[1];

  // Room level registered at home before crossing
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      room_ref_q <= 1'h0;
    end else begin
      room_ref_q <= cell_room;
    end
  end

  // Two-flop synchronisers for straps and room
  always_ff @(posedge in_iface_clk or negedge arst_n) begin
    if (!arst_n) begin
      strap_m_q <= cip_pkg::STRAP_RESET;
      strap_q <= cip_pkg::STRAP_RESET;
      room_m_q <= 1'h0;
      room_q <= 1'h0;
    end else begin
      strap_m_q <= {ca_active_low, par_whole_sel, par_odd_sel, narrow_bus_sel,
                    poll_method_sel};
      strap_q <= strap_m_q;
      room_m_q <= room_ref_q;
      room_q <= room_m_q;
    end
  end

  logic mode_poll;
  logic mode_narrow;
  logic par_odd;
  logic par_whole;
  logic ca_low;
  assign mode_poll = strap_q[cip_pkg::STRAP_POLL];
  assign mode_narrow = strap_q[cip_pkg::STRAP_NARROW];
  assign par_odd = strap_q[cip_pkg::STRAP_ODD];
  assign par_whole = strap_q[cip_pkg::STRAP_WHOLE];
  assign ca_low = strap_q[cip_pkg::STRAP_CA_LOW];

  // ****************************************************
  // Helper functions
  // ****************************************************
  function automatic logic [4:0] next_addr(input logic [4:0] a);
    next_addr = (a >= 5'(NUM_PHY - 1)) ? 5'h00 : 5'(a + 5'h01);
  endfunction : next_addr

  function automatic logic [1:0] rr_pick(input logic [3:0] ca, input logic [1:0] start);
    logic [1:0] idx;
    logic found;
    rr_pick = start;
    found = 1'h0;
    for (int i = 0; i < 4; i++) begin
      idx = 2'(start + 2'(i));
      if (ca[idx] && !found) begin
        rr_pick = idx;
        found = 1'h1;
      end
    end
  endfunction : rr_pick

  function automatic logic odd_bad(input logic [15:0] d, input logic p, input logic odd);
    odd_bad = (^{d, p}) != odd;
  endfunction : odd_bad

  // ****************************************************
  // Pin sampling on the link clock
  // ****************************************************
  logic [3:0] ca_q;
  logic [3:0] ca_eff;
  logic [3:0] we_q;
  logic act_q;
  logic act_p_q;
  logic [15:0] cap_word_q;
  logic [1:0] cap_par_q;
  logic cap_soc_q;
  logic cap_v_q;
  logic cap_first_q;
  logic [4:0] cap_src_q;
  logic [4:0] src_q;

  // R9 avail pins
  // R15 valid pin as avail
  // R2 rising edge sample
  always_ff @(posedge in_iface_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      ca_q <= 4'h0;
    end else begin
      ca_q <= {phy_sel_addr_valid_i, phy_sel_addr_i[4:3], phy_cell_avail_1};
    end
  end
  // Avail polarity is a strap, default active high
  assign ca_eff = ca_q ^ {4{ca_low}};

  // R6 data two edges late
  // R7 idle words ignored
  // R5 width masking
  always_ff @(posedge in_iface_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      act_q <= 1'h0;
      act_p_q <= 1'h0;
      cap_word_q <= 16'h0000;
      cap_par_q <= 2'h0;
      cap_soc_q <= 1'h0;
      cap_v_q <= 1'h0;
      cap_first_q <= 1'h0;
      cap_src_q <= 5'h00;
    end else begin
      act_q <= ~&we_q;
      act_p_q <= act_q;
      cap_v_q <= act_q;
      cap_first_q <= act_q & ~act_p_q;
      if (act_q) begin
        cap_word_q <= mode_narrow ? {8'h00, in_cell_word[7:0]} : in_cell_word;
        cap_par_q <= mode_narrow ? {1'h0, in_word_parity[0]} : in_word_parity;
        cap_soc_q <= in_first_word_flag;
        cap_src_q <= src_q;
      end
    end
  end
  assign rx_word = cap_word_q;
  assign rx_first = cap_first_q;
  assign rx_valid = cap_v_q;
  assign rx_src = cap_src_q;

  // ****************************************************
  // Word checks, flagged by toggles
  // ****************************************************
  logic par_bad;
  logic soc_bad;
  logic par_tgl_q;
  logic soc_tgl_q;
  // R20 parity by byte or word
  assign par_bad = mode_narrow ? odd_bad({8'h00, cap_word_q[7:0]}, cap_par_q[0], par_odd) :
                   par_whole ? odd_bad(cap_word_q, cap_par_q[1], par_odd) :
                   (odd_bad({8'h00, cap_word_q[15:8]}, cap_par_q[1], par_odd) |
                    odd_bad({8'h00, cap_word_q[7:0]}, cap_par_q[0], par_odd));
  // R19 misplaced first flag
  assign soc_bad = cap_soc_q & ~cap_first_q;

  // Toggles survive while ref_clk runs faster than the link clock
  always_ff @(posedge in_iface_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      par_tgl_q <= 1'h0;
      soc_tgl_q <= 1'h0;
    end else begin
      par_tgl_q <= par_tgl_q ^ (cap_v_q & par_bad);
      soc_tgl_q <= soc_tgl_q ^ (cap_v_q & soc_bad);
    end
  end

  // ****************************************************
  // Transfer sequencer
  // ****************************************************
  cip_pkg::cip_state_t st_q, st_d;
  logic [3:0] we_d;
  logic [4:0] addr_q, addr_d;
  logic vld_q, vld_d;
  logic [5:0] cnt_q, cnt_d;
  logic [4:0] ptr_q, ptr_d;
  logic [4:0] resp_q, resp_d;
  logic pend_q, pend_d;
  logic [1:0] rr_q, rr_d;
  logic [4:0] src_d;
  logic [5:0] cell_last;
  logic [1:0] pick;
  logic poll_hit;
  logic dir_hit;

  assign cell_last = mode_narrow ? 6'(CELL_WORDS_NARROW - 1) : 6'(CELL_WORDS_WIDE - 1);
  assign pick = rr_pick(ca_eff, rr_q);
  // R12 avail read from gap cycle
  // R21 room gates a new cell
  assign poll_hit = pend_q & ca_eff[0] & room_q;
  // R3 direct round robin
  assign dir_hit = (|ca_eff) & room_q;

  // Next values; a gap always follows a cell
  always_comb begin
    st_d = st_q;
    we_d = we_q;
    addr_d = addr_q;
    vld_d = vld_q;
    cnt_d = cnt_q;
    ptr_d = ptr_q;
    resp_d = resp_q;
    pend_d = 1'h0;
    rr_d = rr_q;
    src_d = src_q;
    case (st_q)
      cip_pkg::ST_HUNT: begin
        if (mode_poll) begin
          if (poll_hit) begin
            // R14 address held as enable one falls
            // R8 line one carries every cell
            st_d = cip_pkg::ST_XFER;
            we_d = cip_pkg::WE_ONE;
            addr_d = resp_q;
            vld_d = 1'h1;
            cnt_d = cell_last;
            src_d = resp_q;
          end else begin
            // R11 gap after each poll
            // R13 incrementing poll order
            st_d = cip_pkg::ST_GAP;
            addr_d = cip_pkg::GAP_ADDR;
            vld_d = 1'h0;
            resp_d = ptr_q;
            ptr_d = next_addr(ptr_q);
            pend_d = 1'h1;
          end
        end else if (dir_hit) begin
          st_d = cip_pkg::ST_XFER;
          we_d = ~(4'h1 << pick);
          cnt_d = cell_last;
          rr_d = 2'(pick + 2'h1);
          src_d = {3'h0, pick};
        end
      end
      cip_pkg::ST_GAP: begin
        // R4 next address shown
        // R10 five-bit address
        st_d = cip_pkg::ST_HUNT;
        pend_d = pend_q;
        if (mode_poll) begin
          addr_d = ptr_q;
          vld_d = 1'h1;
        end
      end
      cip_pkg::ST_XFER: begin
        // R18 whole cell held
        cnt_d = 6'(cnt_q - 6'h01);
        if (cnt_q == 6'h00) begin
          st_d = cip_pkg::ST_GAP;
          we_d = cip_pkg::WE_IDLE;
          addr_d = cip_pkg::GAP_ADDR;
          vld_d = 1'h0;
        end
      end
      default: begin
        st_d = cip_pkg::ST_GAP;
        we_d = cip_pkg::WE_IDLE;
        addr_d = cip_pkg::GAP_ADDR;
        vld_d = 1'h0;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge in_iface_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      st_q <= cip_pkg::ST_GAP;
      we_q <= cip_pkg::WE_IDLE;
      addr_q <= cip_pkg::GAP_ADDR;
      vld_q <= 1'h0;
      cnt_q <= 6'h00;
      ptr_q <= 5'h00;
      resp_q <= 5'h00;
      pend_q <= 1'h0;
      rr_q <= 2'h0;
      src_q <= 5'h00;
    end else begin
      st_q <= st_d;
      we_q <= we_d;
      addr_q <= addr_d;
      vld_q <= vld_d;
      cnt_q <= cnt_d;
      ptr_q <= ptr_d;
      resp_q <= resp_d;
      pend_q <= pend_d;
      rr_q <= rr_d;
      src_q <= src_d;
    end
  end

  // ****************************************************
  // Shared pin drivers
  // ****************************************************
  logic [4:0] pin_q, pin_oe_q;
  logic av_q, av_oe_q;
  // R8 enables become address bits
  // R9 lower pins as enables
  // R16 valid tracks address
  // R17 address 1F when invalid
  always_ff @(posedge in_iface_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      pin_q <= cip_pkg::GAP_ADDR;
      pin_oe_q <= 5'h00;
      av_q <= 1'h0;
      av_oe_q <= 1'h0;
    end else begin
      pin_q <= mode_poll ? addr_d : {2'h0, we_d[3:1]};
      pin_oe_q <= mode_poll ? cip_pkg::OE_POLL : cip_pkg::OE_DIRECT;
      av_q <= mode_poll & vld_d;
      av_oe_q <= mode_poll;
    end
  end
  assign cell_pull_en_n_1 = we_q[0];
  assign phy_sel_addr_o = pin_q;
  assign phy_sel_addr_oe = pin_oe_q;
  assign phy_sel_addr_valid_o = av_q;
  assign phy_sel_addr_valid_oe = av_oe_q;

  // ****************************************************
  // Event pulses in the ref_clk domain
  // ****************************************************
  logic [2:0] par_s_q, soc_s_q;
  logic par_evt_q, soc_evt_q;
  // Third flop only feeds the edge compare
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      par_s_q <= 3'h0;
      soc_s_q <= 3'h0;
      par_evt_q <= 1'h0;
      soc_evt_q <= 1'h0;
    end else begin
      par_s_q <= {par_s_q[1:0], par_tgl_q};
      soc_s_q <= {soc_s_q[1:0], soc_tgl_q};
      par_evt_q <= par_s_q[2] ^ par_s_q[1];
      soc_evt_q <= soc_s_q[2] ^ soc_s_q[1];
    end
  end
  assign par_err_evt = par_evt_q;
  assign soc_err_evt = soc_evt_q;

  // ****************************************************
  // Checks on the link side
  // ****************************************************
  chk_gap_addr_ones: assert property ( // R11
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (st_q == cip_pkg::ST_GAP && mode_poll && $past(mode_poll))
    |-> (pin_q == 5'h1F && !av_q)) else $error("gap cycle not 1F");
  chk_invalid_addr: assert property ( // R17
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (av_oe_q && !av_q) |-> pin_q == 5'h1F) else $error("invalid address not 1F");
  chk_fall_addr_held: assert property ( // R14
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (mode_poll && $fell(we_q[0])) |-> (av_q && pin_q == src_q && src_q == resp_q))
    else $error("enable one fell without polled address");
  chk_poll_step_up: assert property ( // R13
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (st_q == cip_pkg::ST_HUNT && mode_poll && !poll_hit)
    |=> (ptr_q == next_addr($past(ptr_q)) && resp_q == $past(ptr_q)))
    else $error("poll order not incrementing");
  chk_cell_len_end: assert property ( // R18
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (st_q == cip_pkg::ST_XFER && cnt_q == 6'h00)
    |=> (st_q == cip_pkg::ST_GAP && we_q == 4'hF)) else $error("cell end wrong");
  chk_cell_enable_held: assert property ( // R18
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (st_q == cip_pkg::ST_XFER && cnt_q != 6'h00) |=> $stable(we_q))
    else $error("enable dropped mid-cell");
  chk_room_gate: assert property ( // R21
    @(posedge in_iface_clk) disable iff (!lrst_n)
    $fell(&we_q) |-> $past(room_q)) else $error("cell started without room");
  chk_data_delay: assert property ( // R6
    @(posedge in_iface_clk) disable iff (!lrst_n)
    $fell(&we_q) |-> ##2 (rx_valid && rx_first)) else $error("first word not at second edge");
  chk_idle_ignored: assert property ( // R7
    @(posedge in_iface_clk) disable iff (!lrst_n)
    !act_q |=> (!cap_v_q && $stable(cap_word_q))) else $error("idle word taken");
  chk_parity_flag: assert property ( // R20
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (cap_v_q && par_bad) |=> par_tgl_q != $past(par_tgl_q)) else $error("parity miss");
  chk_soc_flag: assert property ( // R19
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (cap_v_q && soc_bad) |=> soc_tgl_q != $past(soc_tgl_q))
    else $error("misplaced first flag not flagged");
  chk_direct_pins: assert property ( // R9
    @(posedge in_iface_clk) disable iff (!lrst_n)
    (!mode_poll && $past(!mode_poll) && $past(lrst_n))
    |-> (pin_oe_q == 5'h07 && !av_oe_q && we_q[3:1] == pin_q[2:0]))
    else $error("direct pin mapping wrong");
  cov_direct_cell: cover property (
    @(posedge in_iface_clk) disable iff (!lrst_n) !mode_poll && $fell(&we_q));
  cov_poll_cell: cover property (
    @(posedge in_iface_clk) disable iff (!lrst_n) mode_poll && $fell(we_q[0]));
  cov_parity_err: cover property (
    @(posedge in_iface_clk) disable iff (!lrst_n) cap_v_q && par_bad);
endmodule : cip_poll
`default_nettype wire

/* File: tb/cip_phy_model.sv */
// Purpose: behavioural PHY devices facing the input cell poller
// Assumes: straps equal those of the poller under test
// Notes: garbage is driven outside cells, so ignored pins get no help
`timescale 1ns/1ps
`default_nettype none
module cip_phy_model (
  input wire logic clk,
  input wire logic poll,
  input wire logic narrow,
  input wire logic odd,
  input wire logic whole,
  input wire logic ca_low,
  input wire logic en1_n,
  input wire logic [4:0] addr_o,
  input wire logic [4:0] addr_oe,
  input wire logic valid_o,
  input wire logic valid_oe,
  output logic avail1,
  output logic [4:0] addr_in,
  output logic valid_in,
  output logic [15:0] word,
  output logic [1:0] par,
  output logic first
);
  // ****
  // Per-PHY cell store
  // ****
  logic [31:0] pend = '0;
  logic [31:0] bad_p = '0;
  logic [31:0] bad_s = '0;
  logic [15:0] base [32];
  logic [3:0] av_q = '0;
  logic ans_q = 1'b0;
  logic busy = 1'b0;
  logic [4:0] cur = '0;
  logic [5:0] cnt = '0;
  logic [15:0] w;
  wire logic [3:0] en_n = {addr_o[2:0], en1_n};
  wire logic act = poll ? !en1_n : (en_n != 4'hF);
  wire logic [4:0] src = poll ? addr_o :
    (!en_n[0] ? 5'h00 : !en_n[1] ? 5'h01 : !en_n[2] ? 5'h02 : 5'h03);

  // Bench hands one cell to one PHY
  task automatic load(input logic [4:0] phy, input logic [15:0] b, input logic bp,
                      input logic bs);
    base[phy] = b;
    bad_p[phy] = bp;
    bad_s[phy] = bs;
    pend[phy] = 1'b1;
  endtask : load

  function automatic logic [1:0] par_of(input logic [15:0] d);
    logic [1:0] p;
    p[0] = ^d[7:0];
    p[1] = whole ? ^d : ^d[15:8];
    return p ^ {2{odd}};
  endfunction : par_of

  // avail lines; released pins 2..0 show the inverse of the last value, pins 4..3 and valid show avail
  assign avail1 = (poll ? ans_q : av_q[0]) ^ ca_low;
  assign addr_in[2:0] = ~(addr_oe[2:0] ^ addr_o[2:0]);
  assign addr_in[3] = addr_oe[3] ? addr_o[3] : av_q[1] ^ ca_low;
  assign addr_in[4] = addr_oe[4] ? addr_o[4] : av_q[2] ^ ca_low;
  assign valid_in = valid_oe ? valid_o : av_q[3] ^ ca_low;

  initial begin
    word = 16'h0000;
    par = 2'h0;
    first = 1'b0;
  end

  // answer in the cycle after a valid address with enable one high, data two edges after enable falls
  always @(posedge clk) begin
    av_q <= pend[3:0];
    ans_q <= poll && valid_o && en1_n && pend[addr_o];
    if (act) begin
      if (!busy) begin
        cur = src;
        cnt = '0;
        pend[src] = 1'b0;
      end
      busy <= 1'b1;
      w = base[cur] + 16'(cnt);
      word <= w;
      par <= par_of(w) ^ ((bad_p[cur] && cnt == 6'h05) ? (narrow ? 2'h1 : 2'h2) : 2'h0);
      first <= (cnt == 6'h00) || (bad_s[cur] && cnt == 6'h07);
      cnt = cnt + 6'h01;
    end else begin
      busy <= 1'b0;
      word <= ~word;
      par <= ~par;
      first <= ~first;
    end
  end
endmodule : cip_phy_model
`default_nettype wire

/* File: tb/cip_poll_test.sv */
// Purpose: self-checking bench of the input cell poller
// Assumes: each strap set is applied under reset
// Notes: expected words are queued when a cell is handed to the PHY model
`timescale 1ns/1ps
`default_nettype none
module cip_poll_test;
  typedef struct packed {
    logic [15:0] w;
    logic f;
    logic [4:0] s;
  } cip_exp_t;
  logic ref_clk = 1'b0;
  logic lclk = 1'b0;
  logic arst_n = 1'b0;
  logic poll = 1'b0;
  logic narrow = 1'b0;
  logic odd = 1'b0;
  logic whole = 1'b0;
  logic ca_low = 1'b0;
  logic cell_room = 1'b1;
  logic avail1, valid_in, first, en1_n, valid_o, valid_oe, rx_first, rx_valid;
  logic par_evt, soc_evt;
  logic [4:0] addr_in, addr_o, addr_oe, rx_src;
  logic [15:0] word, rx_word;
  logic [1:0] par;
  cip_exp_t expq [$];
  int compares = 0;
  int miscompares = 0;
  int par_seen = 0;
  int soc_seen = 0;
  int exp_par = 0;
  int exp_soc = 0;
  logic [15:0] seed = 16'h0051;

  // ****
  // Clocks and instances
  // ****
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  // Link clock, phase unrelated to ref_clk
  // link under 52 MHz
  initial begin
    #13;
    forever #32 lclk = ~lclk;
  end
  cip_poll i_cip_poll (
    .ref_clk(ref_clk), .arst_n(arst_n), .in_iface_clk(lclk), .poll_method_sel(poll),
    .narrow_bus_sel(narrow), .par_odd_sel(odd), .par_whole_sel(whole),
    .ca_active_low(ca_low), .cell_room(cell_room), .phy_cell_avail_1(avail1),
    .in_cell_word(word), .in_word_parity(par), .in_first_word_flag(first),
    .phy_sel_addr_i(addr_in), .phy_sel_addr_valid_i(valid_in), .cell_pull_en_n_1(en1_n),
    .phy_sel_addr_o(addr_o), .phy_sel_addr_oe(addr_oe), .phy_sel_addr_valid_o(valid_o),
    .phy_sel_addr_valid_oe(valid_oe), .rx_word(rx_word), .rx_first(rx_first),
    .rx_valid(rx_valid), .rx_src(rx_src), .par_err_evt(par_evt), .soc_err_evt(soc_evt)
  );
  cip_phy_model i_cip_phy_model (
    .clk(lclk), .poll(poll), .narrow(narrow), .odd(odd), .whole(whole), .ca_low(ca_low),
    .en1_n(en1_n), .addr_o(addr_o), .addr_oe(addr_oe), .valid_o(valid_o),
    .valid_oe(valid_oe), .avail1(avail1), .addr_in(addr_in), .valid_in(valid_in),
    .word(word), .par(par), .first(first)
  );

  // ****
  // Reporting
  // ****
  task automatic fail(input string msg);
    miscompares++;
    $display("MISMATCH %0t %s", $time, msg);
  endtask : fail
  task automatic cmp_word(input cip_exp_t got, input cip_exp_t exp);
    compares++;
    if (got !== exp) fail($sformatf("word %h exp %h", got, exp));
  endtask : cmp_word
  task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    compares++;
    if (got !== exp) fail($sformatf("%s %h exp %h", what, got, exp));
  endtask : cmp_val
  task automatic conclude();
    if (miscompares == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  // ****
  // Stimulus helpers
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  // Straps only change under reset; sync fills on the two link edges that release the link reset
  task automatic restart(input logic [4:0] cfg);
    @(posedge ref_clk);
    arst_n <= 1'b0;
    poll <= cfg[cip_pkg::STRAP_POLL];
    narrow <= cfg[cip_pkg::STRAP_NARROW];
    odd <= cfg[cip_pkg::STRAP_ODD];
    whole <= cfg[cip_pkg::STRAP_WHOLE];
    ca_low <= cfg[cip_pkg::STRAP_CA_LOW];
    repeat (10) @(posedge ref_clk);
    repeat (2) @(posedge lclk);
    @(posedge ref_clk);
    arst_n <= 1'b1;
    repeat (120) @(posedge ref_clk);
  endtask : restart
  task automatic send(input logic [4:0] phy, input logic bp, input logic bs);
    int n;
    logic [15:0] b;
    logic [15:0] v;
    cip_exp_t e;
    seed = lfsr(seed);
    b = seed;
    n = narrow ? cip_pkg::CELL_WORDS_NARROW : cip_pkg::CELL_WORDS_WIDE;
    for (int k = 0; k < n; k++) begin
      v = b + 16'(k);
      e.w = narrow ? {8'h00, v[7:0]} : v;
      e.f = (k == 0);
      e.s = phy;
      expq.push_back(e);
    end
    i_cip_phy_model.load(phy, b, bp, bs);
    exp_par += bp;
    exp_soc += bs;
  endtask : send
  task automatic drain();
    int t;
    t = 0;
    while ((expq.size() != 0 || i_cip_phy_model.busy) && t < 20000) begin
      @(posedge ref_clk);
      t++;
    end
    if (t >= 20000) begin
      fail("cell never finished");
      conclude();
    end
    repeat (40) @(posedge ref_clk);
  endtask : drain
  task automatic watch_poll();
    logic [4:0] last;
    logic seen;
    logic prev;
    seen = 1'b0;
    prev = 1'b0;
    repeat (40) begin
      @(negedge lclk);
      if (valid_o === 1'b1) begin
        if (seen) cmp_val(16'(addr_o), 16'(5'(last + 5'h01)), "poll order");
        cmp_val(16'(prev), 16'h0000, "no gap");
        last = addr_o;
        seen = 1'b1;
      end else cmp_val(16'(addr_o), 16'h001F, "gap address");
      prev = valid_o;
    end
  endtask : watch_poll

  // ****
  // Result watchers
  // ****
  // captured words against the queue
  always @(negedge lclk) begin
    if (arst_n === 1'b1 && rx_valid === 1'b1) begin
      if (expq.size() == 0) fail("word without cell");
      else cmp_word({rx_word, rx_first, rx_src}, expq.pop_front());
    end
  end
  // Event pulses last one ref_clk cycle; look mid-cycle, away from the launch edge
  always @(negedge ref_clk) begin
    if (par_evt === 1'b1) par_seen++;
    if (soc_evt === 1'b1) soc_seen++;
  end

  // ****
  // Main sequence
  // ****
  initial begin
    logic [4:0] cfgs [4];
    cfgs = '{5'h07, 5'h19, 5'h12, 5'h04};
    foreach (cfgs[i]) begin
      restart(cfgs[i]);
      cmp_val({10'h000, addr_oe, valid_oe}, poll ? 16'h003F : 16'h000E, "pins");
      if (i == 0) begin
        cell_room <= 1'b0;
        repeat (40) @(posedge ref_clk);
        send(5'h09, 1'b0, 1'b0);
        repeat (400) @(posedge ref_clk);
        cmp_val(16'(expq.size()), 16'(cip_pkg::CELL_WORDS_NARROW), "held cell");
        cell_room <= 1'b1;
        drain();
      end
      if (poll) begin
        watch_poll();
        send(5'h1F, 1'b0, 1'b0);
        drain();
        seed = lfsr(seed);
        send(seed[4:0], 1'b1, 1'b0);
        drain();
        seed = lfsr(seed);
        send(seed[4:0], 1'b0, 1'b1);
        drain();
      end else begin
        send(5'h00, 1'b0, 1'b0);
        drain();
        // Round robin from line after the last served
        send(5'h02, 1'b1, 1'b0);
        send(5'h03, 1'b0, 1'b1);
        drain();
      end
      cmp_val(16'(par_seen), 16'(exp_par), "parity events");
      cmp_val(16'(soc_seen), 16'(exp_soc), "flag events");
    end
    conclude();
  end
endmodule : cip_poll_test
`default_nettype wire
